/* ubr_pkg.sv */
// Constants and types shared by the serial interface block
package ubr_pkg;

  // Register byte offsets
  localparam logic [7:0] UBR_CTRL1_OFS = 8'h00;
  localparam logic [7:0] UBR_CTRL2_OFS = 8'h04;
  localparam logic [7:0] UBR_STAT_OFS = 8'h08;
  localparam logic [7:0] UBR_DATA_OFS = 8'h0c;
  localparam logic [7:0] UBR_BAUD_OFS = 8'h10;

  // serial_control_one fields
  localparam int UBR_MOD_EN_BIT = 0;
  localparam int UBR_TX_INV_BIT = 1;
  localparam int UBR_CHAR9_BIT = 2;

  // serial_control_two fields
  localparam int UBR_SBK_BIT = 0;
  localparam int UBR_TE_BIT = 1;
  localparam int UBR_RE_BIT = 2;
  localparam int UBR_TXIE_BIT = 3;
  localparam int UBR_RXIE_BIT = 4;

  // serial_status_one fields
  localparam int UBR_TXE_BIT = 0;
  localparam int UBR_TC_BIT = 1;
  localparam int UBR_RXF_BIT = 2;
  localparam int UBR_NF_BIT = 3;
  localparam int UBR_FE_BIT = 4;
  localparam int UBR_OR_BIT = 5;
  localparam int UBR_PE_BIT = 6;
  localparam int UBR_BKF_BIT = 7;
  localparam int UBR_RPF_BIT = 8;

  // Ninth data bit position in the data register
  localparam int UBR_NINTH_BIT = 8;

  // Reset values
  localparam logic [2:0] UBR_CTRL1_RST = 3'h0;
  localparam logic [4:0] UBR_CTRL2_RST = 5'h00;
  localparam logic [7:0] UBR_BAUD_RST = 8'h00;

  // Sample tick positions within a bit (tick n is stored as n-1)
  localparam logic [3:0] UBR_SMP_A = 4'h2;
  localparam logic [3:0] UBR_SMP_B = 4'h4;
  localparam logic [3:0] UBR_SMP_C = 4'h6;
  localparam logic [3:0] UBR_VOTE_1 = 4'h7;
  localparam logic [3:0] UBR_VOTE_2 = 4'h8;
  localparam logic [3:0] UBR_VOTE_3 = 4'h9;
  localparam logic [3:0] UBR_TICK_LAST = 4'hf;

  // Character lengths in bit times, framing included, and data bits
  localparam logic [3:0] UBR_CHAR_LEN8 = 4'ha;
  localparam logic [3:0] UBR_CHAR_LEN9 = 4'hb;
  localparam logic [3:0] UBR_DATA_LEN8 = 4'h8;
  localparam logic [3:0] UBR_DATA_LEN9 = 4'h9;

  typedef enum logic [4:0] {
    UBR_TX_IDLE = 5'b00001,
    UBR_TX_PRE = 5'b00010,
    UBR_TX_FRAME = 5'b00100,
    UBR_TX_BRK = 5'b01000,
    UBR_TX_MARK = 5'b10000
  } ubr_tx_st_t;

  typedef enum logic [3:0] {
    UBR_RX_SEARCH = 4'b0001,
    UBR_RX_START = 4'b0010,
    UBR_RX_DATA = 4'b0100,
    UBR_RX_STOP = 4'b1000
  } ubr_rx_st_t;

endpackage

/* ubr_remote.sv */
// Remote serial partner: sends frames to the block and captures its output
`timescale 1ns/1ps
`default_nettype none

module ubr_remote (
  // Clock
  input wire logic pclk,
  // Serial line
  output var logic rx_line_pin,
  input wire logic tx_line_pin
);
  initial rx_line_pin = 1'b1;

  // Sixteen clocks per bit; one clock may be flipped to inject noise
  task automatic send(input logic [11:0] fr, input int n, input int flip);
    for (int i = 0; i < n * 16; i++)
    begin
      rx_line_pin <= fr[i / 16] ^ (i == flip);
      @(posedge pclk);
    end
    rx_line_pin <= 1'b1;
  endtask

  // Waits for a start edge, then samples each bit at its middle
  task automatic grab(input logic inv, input int n, output logic [11:0] fr,
                      output int w);
    w = 0;
    fr = '0;
    while (tx_line_pin === !inv && w < 2000)
    begin
      @(posedge pclk);
      w++;
    end
    repeat (8) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      fr[i] = tx_line_pin ^ inv;
      repeat (16) @(posedge pclk);
    end
  endtask
endmodule // ubr_remote

`default_nettype wire

/* ubr_tb.sv */
// Self-checking testbench for the serial interface block
`timescale 1ns/1ps
`default_nettype none

module testbench
  import ubr_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic rx_line_pin;
  wire logic tx_line_pin;
  wire logic tx_irq;
  wire logic rx_irq;
  int err_count;
  int checks_done;
  logic [31:0] rv;
  logic re;
  logic [11:0] fr;
  int w;
  int c;

  ubr_uart uut (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rx_line_pin(rx_line_pin),
    .tx_line_pin(tx_line_pin),
    .tx_irq(tx_irq),
    .rx_irq(rx_irq)
  );

  ubr_remote far_end (
    .pclk(pclk),
    .rx_line_pin(rx_line_pin),
    .tx_line_pin(tx_line_pin)
  );

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checks_done++;
    if (got !== ex)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic is_wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cnt(input int n, input logic v);
    c = 0;
    repeat (n)
    begin
      @(posedge pclk);
      if (tx_line_pin !== v)
        c++;
    end
  endtask

  task automatic t_reset();
    apb(0, UBR_STAT_OFS, 0);
    chk("status", 32'h3, rv);
    apb(0, 8'h20, 0);
    chk("slverr", 32'h1, 32'(re));
    chk("unmapped", 32'h0, rv);
    chk("idle", 32'h1, 32'(tx_line_pin));
  endtask

  task automatic t_tx(input logic inv, input logic nine, input logic [8:0] d);
    int n;
    n = nine ? 11 : 10;
    apb(1, UBR_CTRL2_OFS, 0);
    apb(1, UBR_CTRL1_OFS, 32'({nine, inv, 1'b1}));
    repeat (4) @(posedge pclk);
    chk("idle level", 32'(!inv), 32'(tx_line_pin));
    apb(1, UBR_CTRL2_OFS, 32'h0a);
    apb(1, UBR_DATA_OFS, 32'(d));
    apb(0, UBR_STAT_OFS, 0);
    chk("busy flags", 32'h0, 32'(rv[1:0]));
    far_end.grab(inv, n, fr, w);
    chk("preamble", 32'h1, 32'(w >= n * 16 - 12));
    chk("frame", nine ? 32'({1'b1, d, 1'b0}) : 32'({2'b01, d[7:0], 1'b0}),
        32'(fr));
    repeat (16) @(posedge pclk);
    apb(0, UBR_STAT_OFS, 0);
    chk("done flags", 32'h3, 32'(rv[1:0]));
    chk("tx irq", 32'h1, 32'(tx_irq));
  endtask

  task automatic t_break();
    apb(1, UBR_CTRL1_OFS, 32'h1);
    apb(1, UBR_CTRL2_OFS, 32'h0b);
    far_end.grab(1'b0, 1, fr, w);
    cnt(320, 1'b0);
    chk("break low", 32'h0, 32'(c));
    // A pending frame makes a missing mark bit visible on the line
    apb(1, UBR_DATA_OFS, 32'h0a5);
    apb(0, UBR_STAT_OFS, 0);
    chk("tc in break", 32'h0, 32'(rv[1]));
    apb(1, UBR_CTRL2_OFS, 32'h0a);
    w = 0;
    while (tx_line_pin !== 1'b1 && w < 400)
    begin
      @(posedge pclk);
      w++;
    end
    chk("break end", 32'h1, 32'(w <= 180));
    cnt(16, 1'b1);
    chk("mark", 32'h0, 32'(c));
    // Toggle enable while the frame shifts out, then queue a second byte
    fork
      far_end.grab(1'b0, 10, fr, w);
      begin
        apb(1, UBR_CTRL2_OFS, 32'h08);
        apb(1, UBR_CTRL2_OFS, 32'h0a);
        apb(1, UBR_DATA_OFS, 32'h03c);
      end
    join
    chk("after break", 32'h34a, 32'(fr));
    far_end.grab(1'b0, 10, fr, w);
    chk("queued idle", 32'h1, 32'(w >= 150));
    chk("next frame", 32'h278, 32'(fr));
  endtask

  task automatic rx_case(input logic [11:0] f, input int n, input int flip,
                         input logic [31:0] st, input logic [31:0] d);
    far_end.send(f, n, flip);
    repeat (4) @(posedge pclk);
    apb(0, UBR_STAT_OFS, 0);
    chk("rx status", st, rv & 32'h1fc);
    chk("rx irq", 32'(st[2]), 32'(rx_irq));
    apb(0, UBR_DATA_OFS, 0);
    chk("rx data", d, rv);
    apb(1, UBR_STAT_OFS, 32'hb8);
  endtask

  task automatic t_rx();
    apb(1, UBR_CTRL1_OFS, 32'h1);
    apb(1, UBR_CTRL2_OFS, 32'h14);
    // The receiver needs three idle samples before the first start
    repeat (4) @(posedge pclk);
    rx_case(12'h278, 10, -1, 32'h004, 32'h03c);
    rx_case(12'h278, 10, 56, 32'h00c, 32'h03c);
    rx_case(12'h2aa, 10, 4, 32'h00c, 32'h055);
    rx_case(12'h2aa, 10, 8, 32'h00c, 32'h055);
    rx_case(12'hfff, 1, 0, 32'h000, 32'h055);
    rx_case(12'h102, 10, -1, 32'h014, 32'h081);
    apb(1, UBR_CTRL1_OFS, 32'h5);
    rx_case(12'h74a, 11, -1, 32'h004, 32'h1a5);
    rx_case(12'h000, 11, -1, 32'h094, 32'h000);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    err_count = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx(1'b0, 1'b0, 9'h0a5);
    t_tx(1'b1, 1'b1, 9'h15a);
    t_break();
    t_rx();
    final_report();
  end

  // Cuts a hang short well beyond the expected run length
  initial
  begin
    #3000000;
    err_count++;
    final_report();
  end
endmodule // testbench

`default_nettype wire

/* ubr_uart.sv */
// Serial interface with break, idle, inversion and 16x receive sampling
`timescale 1ns/1ps
`default_nettype none

module ubr_uart
  import ubr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  // Serial line
  input wire logic rx_line_pin,
  output var logic tx_line_pin,
  // Interrupt requests
  output var logic tx_irq,
  output var logic rx_irq
);

  logic [2:0] ctrl1_reg;
  logic [4:0] ctrl2_reg;
  logic [7:0] baud_reg;
  logic [7:0] div_reg;
  logic rt_tick_reg;
  logic te_q_reg;
  ubr_tx_st_t tx_st_reg;
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_tick_reg;
  logic [3:0] tx_bits_reg;
  logic [8:0] tx_buf_reg;
  logic tx_empty_flag;
  logic tx_complete_flag;
  logic idle_pend_reg;
  ubr_rx_st_t rx_st_reg;
  logic [2:0] hist_reg;
  logic [3:0] rt_reg;
  logic [1:0] sv_reg;
  logic nacc_reg;
  logic [8:0] rx_sh_reg;
  logic [3:0] rbit_reg;
  logic rx_done_reg;
  logic rx_stop_reg;
  logic [7:0] serial_data_reg;
  logic rx_ninth_bit;
  logic rx_full_flag;
  logic noise_flag;
  logic framing_err_flag;
  logic overrun_flag;
  logic break_detect_flag;
  logic parity_err_flag;
  logic mod_en;
  logic tx_invert_bit;
  logic char9;
  logic send_break_ctl;
  logic tx_enable_bit;
  logic rx_irq_enable;
  logic tx_irq_enable;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] rd_mux;
  logic [2:0] vote;
  logic [1:0] ones;
  logic vote_maj;
  logic vote_uni;
  logic tx_bit;
  logic [3:0] char_len;
  logic [3:0] data_len;
  logic char_end;
  logic rx_brk;
  logic rx_in_progress_flag;
  logic [8:0] stat_bits;

  assign mod_en = ctrl1_reg[UBR_MOD_EN_BIT];
  assign tx_invert_bit = ctrl1_reg[UBR_TX_INV_BIT];
  assign char9 = ctrl1_reg[UBR_CHAR9_BIT];
  assign send_break_ctl = ctrl2_reg[UBR_SBK_BIT];
  assign tx_enable_bit = ctrl2_reg[UBR_TE_BIT];
  assign tx_irq_enable = ctrl2_reg[UBR_TXIE_BIT];
  assign rx_irq_enable = ctrl2_reg[UBR_RXIE_BIT];
  assign char_len = char9 ? UBR_CHAR_LEN9 : UBR_CHAR_LEN8;
  assign data_len = char9 ? UBR_DATA_LEN9 : UBR_DATA_LEN8;
  assign parity_err_flag = 1'b0;
  assign rx_in_progress_flag = (rx_st_reg != UBR_RX_SEARCH);

  // APB decode; accesses complete with no wait state
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign mapped = (paddr == UBR_CTRL1_OFS) || (paddr == UBR_CTRL2_OFS) ||
    (paddr == UBR_STAT_OFS) || (paddr == UBR_DATA_OFS) ||
    (paddr == UBR_BAUD_OFS);

  assign stat_bits = {rx_in_progress_flag, break_detect_flag,
    parity_err_flag, overrun_flag, framing_err_flag, noise_flag,
    rx_full_flag, tx_complete_flag, tx_empty_flag};

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      UBR_CTRL1_OFS: rd_mux[2:0] = ctrl1_reg;
      UBR_CTRL2_OFS: rd_mux[4:0] = ctrl2_reg;
      UBR_STAT_OFS: rd_mux[8:0] = stat_bits;
      UBR_DATA_OFS: rd_mux[8:0] = {rx_ninth_bit, serial_data_reg};
      UBR_BAUD_OFS: rd_mux[7:0] = baud_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= rd_mux;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1_reg <= UBR_CTRL1_RST;
      ctrl2_reg <= UBR_CTRL2_RST;
      baud_reg <= UBR_BAUD_RST;
      te_q_reg <= 1'b0;
    end
    else
    begin
      te_q_reg <= tx_enable_bit;
      if (wr && paddr == UBR_CTRL1_OFS)
        ctrl1_reg <= pwdata[2:0];
      if (wr && paddr == UBR_CTRL2_OFS)
        ctrl2_reg <= pwdata[4:0];
      if (wr && paddr == UBR_BAUD_OFS)
        baud_reg <= pwdata[7:0];
    end
  end

  // Sample tick at sixteen times the bit rate: one per baud_reg+1 clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg <= 8'h00;
      rt_tick_reg <= 1'b0;
    end
    else if (div_reg >= baud_reg)
    begin
      div_reg <= 8'h00;
      rt_tick_reg <= mod_en;
    end
    else
    begin
      div_reg <= div_reg + 8'h01;
      rt_tick_reg <= 1'b0;
    end
  end

  // Transmitter
  assign tx_bit = (tx_st_reg == UBR_TX_IDLE) ? 1'b1 : tx_sh_reg[0];
  assign char_end = rt_tick_reg && (tx_tick_reg == UBR_TICK_LAST) &&
    ((tx_st_reg == UBR_TX_MARK) || (tx_bits_reg == char_len - 4'h1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_reg <= UBR_TX_IDLE;
      tx_sh_reg <= 11'h7ff;
      tx_tick_reg <= 4'h0;
      tx_bits_reg <= 4'h0;
      tx_buf_reg <= 9'h000;
      tx_empty_flag <= 1'b1;
      idle_pend_reg <= 1'b0;
    end
    else
    begin
      if (tx_enable_bit && !te_q_reg)
        idle_pend_reg <= 1'b1;
      if (!mod_en)
        tx_st_reg <= UBR_TX_IDLE;
      else if (tx_st_reg == UBR_TX_IDLE)
      begin
        tx_tick_reg <= 4'h0;
        tx_bits_reg <= 4'h0;
        if (tx_enable_bit)
        begin
          if (idle_pend_reg)
          begin
            tx_st_reg <= UBR_TX_PRE;
            tx_sh_reg <= 11'h7ff;
            // A toggle landing in this same cycle stays queued
            idle_pend_reg <= tx_enable_bit && !te_q_reg;
          end
          else if (send_break_ctl)
          begin
            tx_st_reg <= UBR_TX_BRK;
            tx_sh_reg <= 11'h000;
          end
          else if (!tx_empty_flag)
          begin
            tx_st_reg <= UBR_TX_FRAME;
            // Start in bit 0, data LSB first, ninth bit, then stop
            tx_sh_reg <= {1'b1, char9 ? tx_buf_reg[8] : 1'b1,
              tx_buf_reg[7:0], 1'b0};
            tx_empty_flag <= 1'b1;
          end
        end
      end
      else if (rt_tick_reg)
      begin
        tx_tick_reg <= tx_tick_reg + 4'h1;
        if (tx_tick_reg == UBR_TICK_LAST)
        begin
          tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
          tx_bits_reg <= tx_bits_reg + 4'h1;
        end
        if (char_end)
        begin
          tx_bits_reg <= 4'h0;
          if (tx_st_reg == UBR_TX_BRK)
          begin
            if (send_break_ctl && tx_enable_bit)
              tx_sh_reg <= 11'h000;
            else
            begin
              tx_st_reg <= UBR_TX_MARK;
              tx_sh_reg <= 11'h7ff;
            end
          end
          else
          begin
            tx_st_reg <= UBR_TX_IDLE;
            // Enable still low at the stop bit drops the buffered data
            if (tx_st_reg == UBR_TX_FRAME && !tx_enable_bit)
              tx_empty_flag <= 1'b1;
          end
        end
      end
      if (wr && paddr == UBR_DATA_OFS)
      begin
        tx_buf_reg <= pwdata[8:0];
        tx_empty_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_line_pin <= 1'b1;
      tx_complete_flag <= 1'b1;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end
    else
    begin
      tx_line_pin <= tx_bit ^ tx_invert_bit;
      tx_complete_flag <= (tx_st_reg == UBR_TX_IDLE) && tx_empty_flag &&
        !idle_pend_reg && !(send_break_ctl && tx_enable_bit);
      tx_irq <= tx_irq_enable &&
        (tx_empty_flag || tx_complete_flag);
      rx_irq <= rx_irq_enable && rx_full_flag;
    end
  end

  // Receiver: three votes are the two held samples plus the current pin
  assign vote = {sv_reg, rx_line_pin};
  assign ones = {1'b0, vote[0]} + {1'b0, vote[1]} + {1'b0, vote[2]};
  assign vote_maj = ones[1];
  assign vote_uni = (vote == 3'b000) || (vote == 3'b111);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_reg <= UBR_RX_SEARCH;
      hist_reg <= 3'h0;
      rt_reg <= 4'h0;
      sv_reg <= 2'h0;
      nacc_reg <= 1'b0;
      rx_sh_reg <= 9'h000;
      rbit_reg <= 4'h0;
      rx_done_reg <= 1'b0;
      rx_stop_reg <= 1'b0;
    end
    else
    begin
      rx_done_reg <= 1'b0;
      if (!mod_en || !ctrl2_reg[UBR_RE_BIT])
      begin
        rx_st_reg <= UBR_RX_SEARCH;
        hist_reg <= 3'h0;
      end
      else if (rt_tick_reg)
      begin
        rt_reg <= rt_reg + 4'h1;
        if (rt_reg == UBR_SMP_A || rt_reg == UBR_SMP_B ||
            rt_reg == UBR_VOTE_1 || rt_reg == UBR_VOTE_2)
          sv_reg <= {sv_reg[0], rx_line_pin};
        case (rx_st_reg)
          UBR_RX_SEARCH:
          begin
            hist_reg <= {hist_reg[1:0], rx_line_pin};
            rt_reg <= 4'h0;
            if (hist_reg == 3'b111 && !rx_line_pin)
            begin
              rx_st_reg <= UBR_RX_START;
              nacc_reg <= 1'b0;
              // Edge sample was tick one, so the next tick is tick two
              rt_reg <= 4'h1;
            end
          end
          UBR_RX_START:
          begin
            if (rt_reg == UBR_SMP_C)
            begin
              if (ones >= 2'd2)
              begin
                rx_st_reg <= UBR_RX_SEARCH;
                hist_reg <= 3'h0;
              end
              else if (ones == 2'd1)
                nacc_reg <= 1'b1;
            end
            if ((rt_reg == UBR_VOTE_1 || rt_reg == UBR_VOTE_2 ||
                rt_reg == UBR_VOTE_3) && rx_line_pin)
              nacc_reg <= 1'b1;
            if (rt_reg == UBR_TICK_LAST)
            begin
              rx_st_reg <= UBR_RX_DATA;
              rbit_reg <= 4'h0;
            end
          end
          UBR_RX_DATA:
          begin
            if (rt_reg == UBR_VOTE_3)
            begin
              rx_sh_reg <= {vote_maj, rx_sh_reg[8:1]};
              if (!vote_uni)
                nacc_reg <= 1'b1;
            end
            if (rt_reg == UBR_TICK_LAST)
            begin
              rbit_reg <= rbit_reg + 4'h1;
              if (rbit_reg == data_len - 4'h1)
                rx_st_reg <= UBR_RX_STOP;
            end
          end
          UBR_RX_STOP:
          begin
            if (rt_reg == UBR_VOTE_3)
            begin
              rx_done_reg <= 1'b1;
              rx_stop_reg <= vote_maj;
              if (!vote_uni)
                nacc_reg <= 1'b1;
              rx_st_reg <= UBR_RX_SEARCH;
              hist_reg <= 3'h0;
            end
          end
          default: rx_st_reg <= UBR_RX_SEARCH;
        endcase
      end
    end
  end

  // Received character into data register and status flags
  assign rx_brk = !rx_stop_reg &&
    (char9 ? (rx_sh_reg == 9'h000) : (rx_sh_reg[8:1] == 8'h00));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_data_reg <= 8'h00;
      rx_ninth_bit <= 1'b0;
      rx_full_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_err_flag <= 1'b0;
      overrun_flag <= 1'b0;
      break_detect_flag <= 1'b0;
    end
    else
    begin
      if (rd && paddr == UBR_DATA_OFS)
        rx_full_flag <= 1'b0;
      if (wr && paddr == UBR_STAT_OFS)
      begin
        if (pwdata[UBR_NF_BIT])
          noise_flag <= 1'b0;
        if (pwdata[UBR_FE_BIT])
          framing_err_flag <= 1'b0;
        if (pwdata[UBR_OR_BIT])
          overrun_flag <= 1'b0;
        if (pwdata[UBR_BKF_BIT])
          break_detect_flag <= 1'b0;
      end
      if (rx_done_reg)
      begin
        if (rx_full_flag)
          overrun_flag <= 1'b1;
        else
        begin
          serial_data_reg <= char9 ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
          rx_ninth_bit <= char9 && rx_sh_reg[8];
        end
        rx_full_flag <= 1'b1;
        if (nacc_reg)
          noise_flag <= 1'b1;
        if (!rx_stop_reg)
          framing_err_flag <= 1'b1;
        if (rx_brk)
        begin
          serial_data_reg <= 8'h00;
          rx_ninth_bit <= 1'b0;
          break_detect_flag <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_break_ends;
    tx_st_reg == UBR_TX_BRK ##1 tx_st_reg != UBR_TX_BRK;
  endsequence

  property p_break_zero;
    tx_st_reg == UBR_TX_BRK |-> tx_sh_reg == 11'h000 || tx_bit == 1'b0;
  endproperty
  a_break_zero: assert property (p_break_zero)
    else $error("break character drives a one");

  property p_break_mark;
    s_break_ends |-> !$past(mod_en) ||
      (tx_st_reg == UBR_TX_MARK && tx_bit);
  endproperty
  a_break_mark: assert property (p_break_mark)
    else $error("break not followed by a mark bit");

  property p_idle_high;
    tx_st_reg == UBR_TX_IDLE |=> tx_line_pin == !$past(tx_invert_bit);
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("idle line not at mark level");

  property p_invert;
    ##1 tx_line_pin == ($past(tx_bit) ^ $past(tx_invert_bit));
  endproperty
  a_invert: assert property (p_invert)
    else $error("line polarity does not follow inversion");

  property p_start_zero;
    tx_st_reg == UBR_TX_IDLE ##1 tx_st_reg == UBR_TX_FRAME |-> !tx_bit;
  endproperty
  a_start_zero: assert property (p_start_zero)
    else $error("frame does not open with a zero");

  property p_break_flags;
    rx_done_reg && rx_brk |=> serial_data_reg == 8'h00 && !rx_ninth_bit &&
      break_detect_flag && framing_err_flag && rx_full_flag;
  endproperty
  a_break_flags: assert property (p_break_flags)
    else $error("break reception flags wrong");

  property p_start_reject;
    rt_tick_reg && rx_st_reg == UBR_RX_START && rt_reg == UBR_SMP_C &&
      ones >= 2'd2 && mod_en && ctrl2_reg[UBR_RE_BIT]
      |=> rx_st_reg == UBR_RX_SEARCH && hist_reg == 3'h0;
  endproperty
  a_start_reject: assert property (p_start_reject)
    else $error("noisy start bit accepted");

  property p_rx_full;
    rx_done_reg |=> rx_full_flag ##1 rx_irq == $past(rx_irq_enable);
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("completed character does not set full flag");

  property p_complete;
    tx_complete_flag && !$past(tx_complete_flag) |->
      $past(tx_st_reg == UBR_TX_IDLE && tx_empty_flag && !idle_pend_reg);
  endproperty
  a_complete: assert property (p_complete)
    else $error("complete flag set while transmitter busy");

endmodule // ubr_uart

`default_nettype wire
